// *** core/acpc_params.svh ***
/*
 * Timing and width constants for the conversion and power control block.
 * Assumes a 10 MHz core clock; the cycle counts are derived from the times.
 */
`ifndef ACPC_PARAMS_SVH
`define ACPC_PARAMS_SVH

`define ACPC_CLK_PERIOD_NS 100
`define ACPC_PWRUP_NS      1500
`define ACPC_CONV_NS       2300
`define ACPC_ACQ_NS        100
`define ACPC_RES_BITS      10
`define ACPC_CNT_BITS      5

// A least time rounds up to whole clock cycles.
`define ACPC_NS_TO_CYC(ns) (((ns) + `ACPC_CLK_PERIOD_NS - 1) / `ACPC_CLK_PERIOD_NS)
`define ACPC_PWRUP_CYC     `ACPC_NS_TO_CYC(`ACPC_PWRUP_NS)
`define ACPC_CONV_CYC      `ACPC_NS_TO_CYC(`ACPC_CONV_NS)
`define ACPC_ACQ_CYC       `ACPC_NS_TO_CYC(`ACPC_ACQ_NS)

`endif

// *** core/acpc_pkg.sv ***
/*
 * Types shared by the conversion and power control block.
 * Assumes nothing of its surroundings.
 */
package acpc_pkg;

	typedef enum logic [1:0] {
		ACPC_ST_DOWN,
		ACPC_ST_IDLE,
		ACPC_ST_CONV
	} acpc_state_t;

	typedef enum logic {
		ACPC_MODE_HIGH_SPEED,
		ACPC_MODE_AUTO_PD
	} acpc_mode_t;

endpackage

// *** core/acpc_sar_if.sv ***
/*
 * Signals between the conversion sequencer and the successive approximation
 * register. Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`include "acpc_params.svh"

interface acpc_sar_if;
	logic                        start;
	logic                        compare_high;
	logic                        done;
	logic [`ACPC_RES_BITS-1:0]   dac_code;

	modport ctrl (output start, output compare_high, input done, input dac_code);
	modport sar  (input start, input compare_high, output done, output dac_code);
endinterface

// *** core/acpc_sar.sv ***
/*
 * Successive approximation register: one result bit per clock, MSB first.
 * Assumes compare_high is the settled comparator answer for the current
 * dac_code, high when the held input is at or above the trial level.
 */
`timescale 1ns/10ps
`include "acpc_params.svh"

module acpc_sar (
	input  wire logic core_clk,
	input  wire logic rst_n,
	acpc_sar_if.sar   sar_bus
);
	import acpc_pkg::*;

	localparam int W = `ACPC_RES_BITS;

	logic [W-1:0] code;
	logic [W-1:0] trial_bit;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			code      <= '0;
			trial_bit <= '0;
		end else if (sar_bus.start) begin
			code      <= {1'b1, {(W-1){1'b0}}};
			trial_bit <= {1'b1, {(W-1){1'b0}}};
		end else if (trial_bit != '0) begin
			// Straight binary: each kept bit weighs its power of two in LSBs.
			code      <= (sar_bus.compare_high ? code : (code & ~trial_bit)) | (trial_bit >> 1);
			trial_bit <= trial_bit >> 1;
		end
	end

	assign sar_bus.dac_code = code;
	assign sar_bus.done     = (trial_bit == '0);
endmodule

// *** core/acpc_top.sv ***
/*
 * Conversion start and power sequencing of a 10-bit successive approximation
 * converter: internal power-up pulse, gated start, busy, mode selection and
 * automatic power-down. Assumes convert_start_n and compare_high are
 * synchronous to core_clk and that the analog side follows dac_code.
 */
// Notes on behaviour
// - A falling edge of the gated start begins a conversion and raises busy.
// - Busy falls when the conversion completes, marking end of conversion.
// - After reset the block is powered down and converts nothing until powered up.
// - A rising edge of the gated start powers the block up.
// - A rising edge on the start pin launches an internal pulse of 1.5 us.
// - Conversion starts on the falling edge of the gated start.
// - The result is a 10-bit straight binary code of one LSB per step.
// - In automatic power-down the block powers down after every conversion.
// - Pin high when busy falls selects high speed, pin low selects power-down.
// - The gated start is the OR of the pin level and the internal pulse.
`timescale 1ns/10ps
`include "acpc_params.svh"

module acpc_top #(
	parameter int PWRUP_CYC = `ACPC_PWRUP_CYC,
	parameter int CONV_CYC  = `ACPC_CONV_CYC
) (
	input  wire logic                      core_clk,
	input  wire logic                      rst_n,
	input  wire logic                      convert_start_n,
	input  wire logic                      compare_high,
	output logic                           busy,
	output logic                           powered_up,
	output logic                           tracking,
	output acpc_pkg::acpc_mode_t           mode,
	output logic [`ACPC_RES_BITS-1:0]      dac_code,
	output logic [`ACPC_RES_BITS-1:0]      result
);
	import acpc_pkg::*;

	localparam int CW = `ACPC_CNT_BITS;
	// Both loads are cut to the counter width, so PWRUP_CYC must stay below 32 and CONV_CYC at or below 32.
	localparam logic [CW-1:0] PWRUP_LOAD = CW'(PWRUP_CYC);
	localparam logic [CW-1:0] CONV_LOAD  = CW'(CONV_CYC - 1);

	logic                 rst_meta;
	logic                 rst_sync_n;
	logic                 pin_prev;
	logic [CW-1:0]        pulse_cnt;
	logic                 gated;
	logic                 gated_prev;
	logic                 gated_rise;
	logic                 gated_fall;
	logic [CW-1:0]        conv_cnt;
	acpc_state_t          state;
	logic                 pin_rise;
	logic                 conv_launch;
	logic                 conv_end;
	acpc_sar_if           sar_bus ();

	// One decode each for launch and end, shared by the counter, busy, mode and result.
	function automatic logic launch_decode(input acpc_state_t st, input logic fall);
		return (st == ACPC_ST_IDLE) && fall;
	endfunction

	function automatic logic end_decode(input acpc_state_t st, input logic [CW-1:0] cnt);
		return (st == ACPC_ST_CONV) && (cnt == '0);
	endfunction

	// The release is synchronised so every flop leaves reset on the same edge.
	// Assertion stays asynchronous, so a reset in mid-conversion drops busy at once.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// The pin idles low through reset, so a zero here gives no false edge afterwards.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= convert_start_n;
		end
	end

	// Edges are seen at clock resolution, so a pin pulse shorter than a clock may be lost.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			gated_prev <= 1'b0;
		end else begin
			gated_prev <= gated;
		end
	end

	// A rising pin restarts the pulse, so a retrigger always grants full power-up time.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pulse_cnt <= '0;
		end else if (pin_rise) begin
			pulse_cnt <= PWRUP_LOAD;
		end else if (pulse_cnt != '0) begin
			pulse_cnt <= pulse_cnt - 1'b1;
		end
	end

	assign gated      = convert_start_n | (pulse_cnt != '0);
	assign gated_rise = gated && !gated_prev;
	assign gated_fall = !gated && gated_prev;

	// The pin alone can hold gated high, so a slow host stretches power-up, never shortens it.
	// Launch and end are decoded once and shared by the counter, busy, mode and result; the state register decodes its own.
	assign pin_rise    = convert_start_n && !pin_prev;
	assign conv_launch = launch_decode(state, gated_fall);
	assign conv_end    = end_decode(state, conv_cnt);

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state <= ACPC_ST_DOWN;
		end else begin
			case (state)
				ACPC_ST_DOWN: begin
					// A fall here can only follow an internal pulse that outlasted the conversion; it is not a start.
					if (gated_rise) begin
						state <= ACPC_ST_IDLE;
					end
				end
				ACPC_ST_IDLE: begin
					// A fall counts only once the rise that powered the block up was seen.
					if (gated_fall) begin
						state <= ACPC_ST_CONV;
					end
				end
				ACPC_ST_CONV: begin
					// Start edges are not looked at until the count runs out.
					// The pin level at this edge alone decides whether power stays on.
					if (conv_cnt == '0) begin
						state <= convert_start_n ? ACPC_ST_IDLE : ACPC_ST_DOWN;
					end
				end
				default: begin
					state <= ACPC_ST_DOWN;
				end
			endcase
		end
	end

	// The count is loaded one short because the loading edge itself raises busy.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			conv_cnt <= '0;
		end else if (conv_launch) begin
			conv_cnt <= CONV_LOAD;
		end else if (conv_cnt != '0) begin
			conv_cnt <= conv_cnt - 1'b1;
		end
	end

	// Busy is a register so the host sees one clean falling edge for its interrupt.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			busy <= 1'b0;
		end else if (conv_launch) begin
			busy <= 1'b1;
		end else if (conv_end) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mode <= ACPC_MODE_AUTO_PD;
		end else if (conv_end) begin
			mode <= convert_start_n ? ACPC_MODE_HIGH_SPEED : ACPC_MODE_AUTO_PD;
		end
	end

	// The result is held from end of conversion until the next one ends.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			result <= '0;
		end else if (conv_end) begin
			result <= sar_bus.dac_code;
		end
	end

	// The trial code is registered so the analog side sees a settled level.
	// It lags the internal code by one clock, which the comparator timing must allow.
	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			dac_code <= '0;
		end else begin
			dac_code <= sar_bus.dac_code;
		end
	end

	assign sar_bus.start        = conv_launch;
	assign sar_bus.compare_high = compare_high;
	// Power follows the state alone, so it drops on the very edge that ends busy.
	assign powered_up           = (state != ACPC_ST_DOWN);
	// The sampler tracks whenever no conversion holds it.
	assign tracking             = !busy;

	// The register runs from the synchronised reset like the rest of the block.
	acpc_sar u_sar (
		.core_clk (core_clk),
		.rst_n    (rst_sync_n),
		.sar_bus  (sar_bus)
	);
endmodule

// *** tb/acpc_host_model.sv ***
/* Host model: drives the start pin and the comparator answer. Assumes core_clk. */
`timescale 1ns/10ps
module acpc_host_model (
	input  wire logic clk,
	output logic      convert_start_n,
	output logic      cmp
);
	initial begin
		convert_start_n = 1'h0;
		cmp = 1'h0;
	end
	task automatic drive(input logic v, input logic c);
		@(posedge clk);
		convert_start_n <= v;
		cmp <= c;
	endtask
endmodule

// *** tb/acpc_top_monitor.sv ***
/* Port checker for acpc_top. Assumes the bench reaches every start path. */
`timescale 1ns/10ps
module acpc_top_monitor import acpc_pkg::*; #(
	parameter int PWRUP_CYC = 15,
	parameter int CONV_CYC  = 23
) (
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       convert_start_n,
	input wire logic       compare_high,
	input wire logic       busy,
	input wire logic       powered_up,
	input wire logic       tracking,
	input wire acpc_mode_t mode,
	input wire logic [9:0] dac_code,
	input wire logic [9:0] result
);
	logic [5:0] n_busy;
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			n_busy <= 6'h00;
		else
			n_busy <= busy ? n_busy + 6'h01 : 6'h00;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_track_inverse: assert property (tracking == !busy) else $error("tracking");
	a_busy_length: assert property ($fell(busy) |-> n_busy == CONV_CYC) else $error("width");
	a_down_idle: assert property (!powered_up |-> !busy) else $error("busy down");
	a_start_cause: assert property (
		$rose(busy) |-> !$past(convert_start_n) && $past(powered_up)) else $error("start");
	a_pulse_hold: assert property (
		$rose(convert_start_n) && !busy |=> !busy [*8]) else $error("pulse");
	a_power_up: assert property (
		$rose(convert_start_n) |-> ##[1:3] powered_up) else $error("power up");
	a_mode_select: assert property ($fell(busy) |-> mode == ($past(convert_start_n) ?
		ACPC_MODE_HIGH_SPEED : ACPC_MODE_AUTO_PD)) else $error("mode");
	a_power_down: assert property (
		$fell(busy) |-> powered_up == (mode == ACPC_MODE_HIGH_SPEED)) else $error("power down");
	a_trial_start: assert property (
		$rose(busy) |=> dac_code == 10'h200) else $error("first trial code");
	a_result_hold: assert property (!$fell(busy) |-> $stable(result)) else $error("result");
	c_auto: cover property ($fell(busy) && mode == ACPC_MODE_AUTO_PD);
	c_fast: cover property ($fell(busy) && mode == ACPC_MODE_HIGH_SPEED);
	c_up: cover property ($rose(powered_up));
endmodule
bind acpc_top acpc_top_monitor #(.PWRUP_CYC(PWRUP_CYC), .CONV_CYC(CONV_CYC)) mon_i (
	.core_clk(core_clk), .rst_n(rst_n), .convert_start_n(convert_start_n),
	.compare_high(compare_high), .busy(busy), .powered_up(powered_up), .tracking(tracking),
	.mode(mode), .dac_code(dac_code), .result(result));

// *** tb/tb.sv ***
/* Bench for acpc_top. Assumes the host model owns the start pin. */
`timescale 1ns/10ps
module tb;
	import acpc_pkg::*;
	localparam int PW = 15;
	typedef struct {logic c; int act; logic [9:0] res; acpc_mode_t m;} acpc_row_t;
	logic       core_clk, rst_n, convert_start_n, compare_high, busy, powered_up, tracking;
	acpc_mode_t mode;
	logic [9:0] dac_code, result;
	int         n_errors, comparisons, lat, up;
	// Action in busy: 0 none, 1 raise and hold the pin, 2 a short pin pulse.
	acpc_row_t rows [4] = '{'{1'h1, 0, 10'h3ff, ACPC_MODE_AUTO_PD},
		'{1'h0, 1, 10'h000, ACPC_MODE_HIGH_SPEED}, '{1'h1, 2, 10'h3ff, ACPC_MODE_AUTO_PD},
		'{1'h0, 0, 10'h000, ACPC_MODE_AUTO_PD}};
	acpc_host_model host_i (.clk(core_clk), .convert_start_n(convert_start_n), .cmp(compare_high));
	acpc_top #(.PWRUP_CYC(PW), .CONV_CYC(23)) acpc_top_i (.core_clk(core_clk), .rst_n(rst_n),
		.convert_start_n(convert_start_n), .compare_high(compare_high), .busy(busy),
		.powered_up(powered_up), .tracking(tracking), .mode(mode), .dac_code(dac_code),
		.result(result));
	task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_reset;
		rst_n <= 1'h0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'h1;
	endtask
	task automatic print_verdict;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		repeat (5000) @(posedge core_clk);
		n_errors++;
		print_verdict;
	end
	initial begin
		do_reset;
		repeat (10) @(posedge core_clk);
		#1 check("idle power", 10'h0, 10'(powered_up));
		foreach (rows[i]) begin
			up = powered_up;
			if (convert_start_n === 1'h0) begin
				host_i.drive(1'h1, rows[i].c);
				host_i.drive(1'h1, rows[i].c);
			end
			host_i.drive(1'h0, rows[i].c);
			lat = 0;
			while (busy !== 1'h1 && lat < 40) begin
				@(posedge core_clk);
				#1 lat++;
			end
			check("start wait", 10'h1, 10'(up ? lat <= 3 : lat >= PW - 3));
			repeat (5) @(posedge core_clk);
			if (rows[i].act > 0)
				host_i.drive(1'h1, rows[i].c);
			if (rows[i].act == 2)
				host_i.drive(1'h0, rows[i].c);
			lat = 0;
			while (busy === 1'h1 && lat < 40) begin
				@(posedge core_clk);
				#1 lat++;
			end
			check("result", rows[i].res, result);
			check("mode", 10'(rows[i].m), 10'(mode));
			check("dac code", rows[i].res, dac_code);
			check("power", 10'(rows[i].m == ACPC_MODE_HIGH_SPEED), 10'(powered_up));
			repeat (3) @(posedge core_clk);
			#1 check("no restart", 10'h0, 10'(busy));
		end
		host_i.drive(1'h1, 1'h1);
		host_i.drive(1'h0, 1'h1);
		repeat (20) @(posedge core_clk);
		do_reset;
		#1 check("reset busy", 10'h0, 10'(busy));
		check("reset result", 10'h0, result);
		check("reset mode", 10'(ACPC_MODE_AUTO_PD), 10'(mode));
		print_verdict;
	end
endmodule
